// ===== rffe_map.svh
// Offsets, field positions, reset values and timing figures of the
// RF front-end command registers. Assumes byte addresses are 4 x index.
`ifndef RFFE_MAP_SVH
`define RFFE_MAP_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define RFFE_IDX_CMD_PORT   6'h00
`define RFFE_IDX_STATUS     6'h01
`define RFFE_IDX_TIMING     6'h35
`define RFFE_IDX_SLICER     6'h36
`define RFFE_IDX_MONITOR    6'h37
`define RFFE_IDX_SPEED      6'h39

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RFFE_SL_BUF_BIT     7
`define RFFE_SL_EXT_BIT     6
`define RFFE_SL_GAIN_LSB    3
`define RFFE_SL_LVL_BIT     0
`define RFFE_MON_MIR_BIT    7
`define RFFE_MON_FLAW_BIT   6
`define RFFE_MON_SP_BIT     5
`define RFFE_MON_TRK_BIT    1
`define RFFE_MON_FOC_BIT    0
`define RFFE_SPD_DBL_BIT    0
`define RFFE_SPD_POL_BIT    3
`define RFFE_SPD_EQ_BIT     4
`define RFFE_SPD_CUR_BIT    5
`define RFFE_SPD_LD_BIT     7
`define RFFE_SPD_MASK       8'hB9

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RFFE_RST_TIMING     7'h00
`define RFFE_RST_SLICER     8'h00
`define RFFE_RST_MONITOR    8'h00
`define RFFE_RST_SPEED      8'h08
`define RFFE_RST_STEPS      4'h1
`define RFFE_STEP_PS        7460

`endif

// ===== rffe_pkg.sv
// Types shared by the RF front-end command register bank.
// Assumes a single 20 MHz clock domain.
package rffe_pkg;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        pend;
    logic [7:0]  code;
    logic [6:0]  timing;
    logic [3:0]  steps;
    logic [7:0]  slicer;
    logic [7:0]  monitor;
    logic [7:0]  speed;
    logic        probe;
    logic        ack;
    logic [31:0] dat;
  } rffe_state_t;

endpackage

// ===== rffe_cmd_regs.sv
// Command-loaded configuration latches of the RF front end, reached
// over a classic Wishbone slave. Assumes inputs synchronous to clk_i.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`include "rffe_map.svh"

module rffe_cmd_regs
  import rffe_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Detector sources
  input  wire logic        mirror_detect_i,
  input  wire logic        flaw_detect_i,
  input  wire logic        short_pulse_i,
  // Timing setting
  output logic      [6:0]  pulse_sample_delay_o,
  output logic      [3:0]  fine_delay_steps_o,
  // Slicer and RF load
  output logic             slicer_out_buffer_en_o,
  output logic             ext_rf_load_sel_o,
  output logic      [2:0]  rf_fine_gain_o,
  output logic             rf_out_level_sel_o,
  // Test monitor and amplifier loads
  output logic             monitor_sel_mirror_o,
  output logic             monitor_sel_flaw_o,
  output logic             monitor_sel_short_pulse_o,
  output logic             analog_probe_out_o,
  output logic             tracking_load_ext_sel_o,
  output logic             focus_load_ext_sel_o,
  // Speed, laser and input
  output logic             double_speed_sel_o,
  output logic             laser_loop_polarity_o,
  output logic             eq_path_sel_o,
  output logic             pickup_current_input_o,
  output logic             laser_power_loop_en_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic known_code(input logic [7:0] c);
    known_code = (c == 8'h35) || (c == 8'h36)
              || (c == 8'h37) || (c == 8'h39);
  endfunction

  // Latches one parameter byte under its command code.
  function automatic rffe_state_t apply(
    input rffe_state_t s,
    input logic [7:0]  c,
    input logic [7:0]  p
  );
    rffe_state_t t;
    t = s;
    unique case (c)
      8'h35:
      begin
        t.timing = p[6:0];
        t.steps  = {1'b0, p[2:0]} + 4'h1;
      end
      8'h36:
      begin
        t.slicer = p;
      end
      8'h37:
      begin
        t.monitor = p;
      end
      8'h39:
      begin
        t.speed = p & `RFFE_SPD_MASK;
      end
      default:
      begin
        t = s;
      end
    endcase
    return t;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rffe_state_t st_r;
  rffe_state_t st_nxt;
  logic        req;
  logic        wr;
  logic [5:0]  idx;

  assign req = cyc_i && stb_i && !st_r.ack;
  assign wr  = req && we_i && sel_i[0];
  assign idx = adr_i[7:2];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.ack = req;
    st_nxt.dat = 32'h0000_0000;
    // Only one source drives the probe; the host keeps the
    // selection one-hot, so the fixed priority is never seen.
    if (st_r.monitor[`RFFE_MON_MIR_BIT])
    begin
      st_nxt.probe = mirror_detect_i;
    end
    else if (st_r.monitor[`RFFE_MON_FLAW_BIT])
    begin
      st_nxt.probe = flaw_detect_i;
    end
    else if (st_r.monitor[`RFFE_MON_SP_BIT])
    begin
      st_nxt.probe = short_pulse_i;
    end
    else
    begin
      st_nxt.probe = 1'b0;
    end
    if (wr)
    begin
      if (idx == `RFFE_IDX_CMD_PORT)
      begin
        // A code waits here until its parameter arrives.
        if (st_r.pend)
        begin
          st_nxt      = apply(st_nxt, st_r.code, dat_i[7:0]);
          st_nxt.pend = 1'b0;
        end
        else if (known_code(dat_i[7:0]))
        begin
          st_nxt.pend = 1'b1;
          st_nxt.code = dat_i[7:0];
        end
      end
      else if (idx == `RFFE_IDX_TIMING || idx == `RFFE_IDX_SLICER
            || idx == `RFFE_IDX_MONITOR || idx == `RFFE_IDX_SPEED)
      begin
        st_nxt = apply(st_nxt, {2'b00, idx}, dat_i[7:0]);
      end
    end
    else if (req && !we_i && idx == `RFFE_IDX_STATUS)
    begin
      st_nxt.dat = {23'h00_0000, st_r.pend, st_r.code};
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r.pend    <= 1'b0;
      st_r.code    <= 8'h00;
      st_r.timing  <= `RFFE_RST_TIMING;
      st_r.steps   <= `RFFE_RST_STEPS;
      st_r.slicer  <= `RFFE_RST_SLICER;
      st_r.monitor <= `RFFE_RST_MONITOR;
      st_r.speed   <= `RFFE_RST_SPEED;
      st_r.probe   <= 1'b0;
      st_r.ack     <= 1'b0;
      st_r.dat     <= 32'h0000_0000;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ack_o                     = st_r.ack;
  assign dat_o                     = st_r.dat;
  assign pulse_sample_delay_o      = st_r.timing;
  assign fine_delay_steps_o        = st_r.steps;
  assign slicer_out_buffer_en_o    = st_r.slicer[`RFFE_SL_BUF_BIT];
  assign ext_rf_load_sel_o         = st_r.slicer[`RFFE_SL_EXT_BIT];
  assign rf_fine_gain_o            = st_r.slicer[`RFFE_SL_GAIN_LSB +: 3];
  assign rf_out_level_sel_o        = st_r.slicer[`RFFE_SL_LVL_BIT];
  assign monitor_sel_mirror_o      = st_r.monitor[`RFFE_MON_MIR_BIT];
  assign monitor_sel_flaw_o        = st_r.monitor[`RFFE_MON_FLAW_BIT];
  assign monitor_sel_short_pulse_o = st_r.monitor[`RFFE_MON_SP_BIT];
  assign analog_probe_out_o        = st_r.probe;
  assign tracking_load_ext_sel_o   = st_r.monitor[`RFFE_MON_TRK_BIT];
  assign focus_load_ext_sel_o      = st_r.monitor[`RFFE_MON_FOC_BIT];
  assign double_speed_sel_o        = st_r.speed[`RFFE_SPD_DBL_BIT];
  assign laser_loop_polarity_o     = st_r.speed[`RFFE_SPD_POL_BIT];
  assign eq_path_sel_o             = st_r.speed[`RFFE_SPD_EQ_BIT];
  assign pickup_current_input_o    = st_r.speed[`RFFE_SPD_CUR_BIT];
  assign laser_power_loop_en_o     = st_r.speed[`RFFE_SPD_LD_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic dwr_t;
  logic dwr_s;
  logic pwr_code;
  assign dwr_t    = wr && idx == `RFFE_IDX_TIMING;
  assign dwr_s    = wr && idx == `RFFE_IDX_SPEED;
  assign pwr_code = wr && idx == `RFFE_IDX_CMD_PORT && !st_r.pend;
  logic pwr_par;
  logic ld_sl;
  logic ld_mo;
  assign pwr_par  = wr && idx == `RFFE_IDX_CMD_PORT && st_r.pend;
  assign ld_sl    = wr && (idx == `RFFE_IDX_SLICER || (pwr_par && st_r.code == 8'h36));
  assign ld_mo    = wr && (idx == `RFFE_IDX_MONITOR || (pwr_par && st_r.code == 8'h37));

  chk_timing_load: assert property (
    dwr_t |=> pulse_sample_delay_o == $past(dat_i[6:0]))
    else $error("timing byte not latched");

  chk_timing_seven: assert property (
    dwr_t ##1 !dwr_t[*2] |-> pulse_sample_delay_o == $past(dat_i[6:0], 2))
    else $error("timing field lost");

  chk_fine_steps: assert property (
    fine_delay_steps_o == {1'b0, pulse_sample_delay_o[2:0]} + 4'h1)
    else $error("fine delay step count wrong");

  chk_probe_mirror: assert property (
    monitor_sel_mirror_o |=> analog_probe_out_o == $past(mirror_detect_i))
    else $error("probe not following mirror");

  chk_probe_flaw: assert property (
    monitor_sel_flaw_o && !monitor_sel_mirror_o
      |=> analog_probe_out_o == $past(flaw_detect_i))
    else $error("probe not following flaw");

  chk_probe_short: assert property (
    monitor_sel_short_pulse_o && !monitor_sel_mirror_o && !monitor_sel_flaw_o
      |=> analog_probe_out_o == $past(short_pulse_i))
    else $error("probe not following short pulse");

  chk_speed_zeros: assert property (
    (st_r.speed & ~`RFFE_SPD_MASK) == 8'h00)
    else $error("fixed zero bits set");

  chk_speed_load: assert property (
    dwr_s |=> double_speed_sel_o == $past(dat_i[0])
          && laser_loop_polarity_o == $past(dat_i[3]))
    else $error("speed byte not latched");

  chk_laser_loop: assert property (
    dwr_s |=> laser_power_loop_en_o == $past(dat_i[7])
          && pickup_current_input_o == $past(dat_i[5])
          && eq_path_sel_o == $past(dat_i[4]))
    else $error("laser loop bit not latched");

  // Reset itself is the trigger here, so the default disable must not apply.
  chk_reset_vals: assert property (
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> laser_loop_polarity_o && !laser_power_loop_en_o
      && !double_speed_sel_o && pulse_sample_delay_o == 7'h00
      && fine_delay_steps_o == 4'h1 && !ack_o && !analog_probe_out_o
      && !monitor_sel_mirror_o && !slicer_out_buffer_en_o && !eq_path_sel_o)
    else $error("defaults not restored");

  chk_code_hold: assert property (
    pwr_code |=> $stable(st_r.timing) && $stable(st_r.speed)
              && $stable(st_r.slicer) && $stable(st_r.monitor))
    else $error("setting changed before parameter");

  chk_ack_pulse: assert property (
    ack_o |=> !ack_o)
    else $error("ack held too long");

  // ----------------------------------------------------------------
  // Loads through the command port and refused requests
  // ----------------------------------------------------------------
  // A parameter through the port must land exactly like a direct
  // write; a slip here would only show on the paired path.
  chk_port_timing: assert property (
    pwr_par && st_r.code == 8'h35 |=> pulse_sample_delay_o == $past(dat_i[6:0]))
    else $error("port timing byte not latched");

  chk_port_polarity: assert property (
    pwr_par && st_r.code == 8'h39 |=> laser_loop_polarity_o == $past(dat_i[3]))
    else $error("laser loop polarity not latched");

  chk_port_eq: assert property (
    pwr_par && st_r.code == 8'h39 |=> eq_path_sel_o == $past(dat_i[4]))
    else $error("equaliser path not latched");

  chk_port_pickup: assert property (
    pwr_par && st_r.code == 8'h39 |=> pickup_current_input_o == $past(dat_i[5]))
    else $error("pickup input type not latched");

  chk_slicer_buf: assert property (
    ld_sl |=> slicer_out_buffer_en_o == $past(dat_i[7])
          && rf_out_level_sel_o == $past(dat_i[0]))
    else $error("slicer buffer bit not latched");

  chk_fine_gain: assert property (
    ld_sl |=> rf_fine_gain_o == $past(dat_i[5:3])
          && ext_rf_load_sel_o == $past(dat_i[6]))
    else $error("fine gain field not latched");

  chk_track_load: assert property (
    ld_mo |=> tracking_load_ext_sel_o == $past(dat_i[1]))
    else $error("tracking load bit not latched");

  chk_focus_load: assert property (
    ld_mo |=> focus_load_ext_sel_o == $past(dat_i[0]))
    else $error("focus load bit not latched");

  chk_pend_clear: assert property (
    pwr_par |=> !st_r.pend)
    else $error("pending code not cleared");

  chk_refused_sel: assert property (
    req && we_i && !sel_i[0] |=> $stable(st_r.timing) && $stable(st_r.speed)
      && $stable(st_r.slicer) && $stable(st_r.monitor) && $stable(st_r.pend))
    else $error("write without low lane took effect");

  chk_probe_idle: assert property (
    !monitor_sel_mirror_o && !monitor_sel_flaw_o && !monitor_sel_short_pulse_o
      |=> !analog_probe_out_o)
    else $error("probe driven with no source");

  chk_ack_answer: assert property (
    req |=> ack_o)
    else $error("request not answered next cycle");

  chk_idle_data: assert property (
    !ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack cycle");

  cov_port_pair: cover property (
    pwr_code ##[1:20] (wr && idx == `RFFE_IDX_CMD_PORT && st_r.pend));

  cov_direct_speed: cover property (
    dwr_s ##1 laser_power_loop_en_o);

  cov_status_read: cover property (
    req && !we_i && idx == `RFFE_IDX_STATUS ##1 dat_o[8]);

  cov_port_polarity: cover property (
    pwr_par && st_r.code == 8'h39);

  cov_probe_flaw: cover property (
    monitor_sel_flaw_o ##1 analog_probe_out_o);

endmodule // rffe_cmd_regs

// ===== rffe_host_model.sv
// Host model: sends command and parameter bytes over classic Wishbone.
// Assumes one clock; the bench calls its tasks through the instance.
`timescale 1ns/1ps

module rffe_host_model
  import rffe_pkg::*;
(
  // Clock and bus answer
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  // Bus request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] wdat_o
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial
  begin
    cyc_o  = 1'b0;
    stb_o  = 1'b0;
    we_o   = 1'b0;
    adr_o  = 8'h00;
    sel_o  = 4'h0;
    wdat_o = 32'h00000000;
  end

  // The wait has no limit of its own; only the bench timeout ends it.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o  <= 1'b1;
    stb_o  <= 1'b1;
    we_o   <= w;
    adr_o  <= a;
    sel_o  <= s;
    wdat_o <= {24'h000000, d};
    do
      @(posedge clk_i);
    while (ack_i !== 1'b1);
    q = rdat_i;
    cyc_o  <= 1'b0;
    stb_o  <= 1'b0;
    wdat_o <= ~wdat_o;
  endtask

  task automatic cmd(input logic [7:0] c, input logic [7:0] p, input logic dir,
                     output logic [7:0] sent);
    logic [31:0] q;
    sent = p;
    if (c == 8'h35)
      sent[7] = 1'b0;
    // The speed byte is masked with 8'hB9, so bits 6, 2 and 1 are sent as zero;
    // bit 5 passes through and may take any value.
    if (c == 8'h39)
      sent = p & 8'hB9;
    if (c == 8'h37 && $countones(p[7:5]) > 1)
      sent[6:5] = 2'b00;
    if (dir)
      xfer(1'b1, {c[5:0], 2'b00}, 4'hF, sent, q);
    else
    begin
      xfer(1'b1, 8'h00, 4'hF, c, q);
      xfer(1'b1, 8'h00, 4'hF, sent, q);
    end
  endtask
endmodule // rffe_host_model

// ===== test_rf_front_end_command_regs.sv
// Self-checking bench for the RF front-end command register bank.
// Assumes the host model file and the design files compile first.
`timescale 1ns/1ps

module test_rf_front_end_command_regs;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i, stb_i, we_i, ack_o;
  logic [7:0]  adr_i, tm, sl, mo, sp, c, p, s;
  logic [3:0]  sel_i, fine_delay_steps_o;
  logic [31:0] dat_i, dat_o, q;
  logic [6:0]  pulse_sample_delay_o;
  logic [2:0]  rf_fine_gain_o;
  logic [2:0]  det = 3'h0;
  logic        slicer_out_buffer_en_o, ext_rf_load_sel_o, rf_out_level_sel_o;
  logic        monitor_sel_mirror_o, monitor_sel_flaw_o, monitor_sel_short_pulse_o;
  logic        analog_probe_out_o, tracking_load_ext_sel_o, focus_load_ext_sel_o;
  logic        double_speed_sel_o, laser_loop_polarity_o, eq_path_sel_o;
  logic        pickup_current_input_o, laser_power_loop_en_o;
  int          fails, compares, cyc_n;
  logic [7:0]  codes [5] = '{8'h35, 8'h36, 8'h37, 8'h39, 8'h38};
  wire  [31:0] cfg = {5'h00, pulse_sample_delay_o, fine_delay_steps_o,
    slicer_out_buffer_en_o, ext_rf_load_sel_o, rf_fine_gain_o, rf_out_level_sel_o,
    monitor_sel_mirror_o, monitor_sel_flaw_o, monitor_sel_short_pulse_o,
    tracking_load_ext_sel_o, focus_load_ext_sel_o, double_speed_sel_o,
    pickup_current_input_o, eq_path_sel_o, laser_loop_polarity_o, laser_power_loop_en_o};

  always #25 clk_i = ~clk_i;

  rffe_cmd_regs dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .mirror_detect_i(det[2]), .flaw_detect_i(det[1]),
    .short_pulse_i(det[0]), .pulse_sample_delay_o, .fine_delay_steps_o,
    .slicer_out_buffer_en_o, .ext_rf_load_sel_o, .rf_fine_gain_o, .rf_out_level_sel_o,
    .monitor_sel_mirror_o, .monitor_sel_flaw_o, .monitor_sel_short_pulse_o,
    .analog_probe_out_o, .tracking_load_ext_sel_o, .focus_load_ext_sel_o,
    .double_speed_sel_o, .laser_loop_polarity_o, .eq_path_sel_o,
    .pickup_current_input_o, .laser_power_loop_en_o);

  rffe_host_model host_u (.clk_i, .ack_i(ack_o), .rdat_i(dat_o), .cyc_o(cyc_i),
    .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .wdat_o(dat_i));

  // ----------------------------------------------------------------
  // Expectations, comparison and closing
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_cfg();
    exp_cfg = {5'h00, tm[6:0], {1'b0, tm[2:0]} + 4'h1, sl[7:3], sl[0],
               mo[7:5], mo[1:0], sp[0], sp[5:3], sp[7]};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic report_and_stop;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 5000)
    begin
      fails++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hB687CF37));
    {tm, sl, mo, sp} = 32'h00000008;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk(cfg, exp_cfg());
    $display("test reset done");
    // A code alone must leave every setting as it was.
    host_u.xfer(1'b1, 8'h00, 4'hF, 8'h35, q);
    #1 chk(cfg, exp_cfg());
    host_u.xfer(1'b0, 8'h04, 4'hF, 8'h00, q);
    chk(q, 32'h00000135);
    host_u.xfer(1'b1, 8'h00, 4'hF, 8'h7F, q);
    tm = 8'h7F;
    #1 chk(cfg, exp_cfg());
    $display("test pending done");
    for (int i = 0; i < 30; i++)
    begin
      c = codes[$urandom % 5];
      p = (c == 8'h38) ? 8'h00 : 8'($urandom);
      host_u.cmd(c, p, 1'($urandom), s);
      case (c)
        8'h35: tm = s;
        8'h36: sl = s;
        8'h37: mo = s;
        8'h39: sp = s;
        default: ;
      endcase
      #1 chk(cfg, exp_cfg());
    end
    $display("test random done");
    host_u.xfer(1'b1, 8'hE4, 4'hE, 8'hFF, q);
    #1 chk(cfg, exp_cfg());
    host_u.xfer(1'b0, 8'hE4, 4'hF, 8'h00, q);
    chk(q, 32'h00000000);
    host_u.xfer(1'b0, 8'hFC, 4'hF, 8'h00, q);
    chk(q, 32'h00000000);
    $display("test refuse done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    {tm, sl, mo, sp} = 32'h00000008;
    #1 chk(cfg, exp_cfg());
    $display("test mid reset done");
    for (int k = 0; k < 4; k++)
    begin
      host_u.cmd(8'h37, (8'h80 >> k) & 8'hE0 | 8'($urandom % 4), 1'b0, s);
      mo = s;
      repeat (8)
      begin
        @(posedge clk_i);
        det <= 3'($urandom);
        @(posedge clk_i);
        #1 chk(analog_probe_out_o, mo[7] ? det[2] : mo[6] ? det[1] : mo[5] & det[0]);
      end
    end
    $display("test probe done");
    report_and_stop();
  end
endmodule // test_rf_front_end_command_regs
